// *** dv/ppc_checker.sv ***
// Purpose: Port-level checks of the positioning core
// Assumes: No origin event coincides with a move start
// Notes: Bound to every ppc_positioner
`timescale 1ns/1ps
module ppc_checker
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Commands
  input wire i_move_start,
  input wire i_move_abs,
  input wire i_counter_preset_command,
  input wire [31:0] i_preset_value,
  input wire i_origin_found,
  input wire i_out_reset,
  input wire i_program_mode,
  // Status
  input wire o_busy,
  input wire o_done,
  input wire o_exec_error,
  input wire o_no_origin,
  input wire [31:0] o_position_counter,
  input wire o_reverse_direction
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire go = i_move_start && !o_busy && !i_counter_preset_command && !i_origin_found;

  AST_ABS_REFUSE: assert property (go && i_move_abs && o_no_origin |=> o_exec_error && !o_busy)
    else $error("absolute start without origin not refused");
  AST_IDLE_HOLD: assert property (!o_busy && !$past(o_busy) && !$past(i_counter_preset_command)
    && !$past(i_origin_found) |-> $stable(o_position_counter))
    else $error("position moved while idle");
  AST_REL_ZERO: assert property (go && !i_move_abs && o_no_origin && !i_out_reset
    && !$rose(i_program_mode) |=> o_position_counter == 32'h0)
    else $error("position not cleared before relative move");
  AST_PRESET: assert property (i_counter_preset_command && !o_busy && !i_out_reset && !i_program_mode
    && !i_move_start |=> !o_no_origin && o_position_counter == $past(i_preset_value))
    else $error("preset did not define origin");
  AST_OUT_RESET: assert property (i_out_reset |=> o_no_origin)
    else $error("output reset kept origin");
  AST_PROG: assert property ($rose(i_program_mode) |=> o_no_origin)
    else $error("program mode kept origin");
  AST_STEP: assert property ($past(o_busy) && !$stable(o_position_counter)
    |-> o_position_counter == $past(o_position_counter) + (o_reverse_direction ? 32'hffff_ffff : 32'h1))
    else $error("position step wrong");
  AST_DIR: assert property (o_busy && $past(o_busy) && $past(o_busy, 2)
    |-> $stable(o_reverse_direction) && !o_done)
    else $error("direction changed in a move");
endmodule

bind ppc_positioner ppc_checker ppc_checker_inst (.i_clk, .i_rst_n, .i_move_start, .i_move_abs,
  .i_counter_preset_command, .i_preset_value, .i_origin_found, .i_out_reset, .i_program_mode,
  .o_busy, .o_done, .o_exec_error, .o_no_origin, .o_position_counter, .o_reverse_direction);

// *** dv/ppc_drive_model.sv ***
// Purpose: Step and direction driver that counts motor steps
// Assumes: Direction settles before each step edge
// Notes: Pulse width is not judged here
`timescale 1ns/1ps
module ppc_drive_model
(
  // Clock
  input wire i_clk,
  // Driver pins
  input wire i_pulse,
  input wire i_reverse,
  // Step count
  output logic signed [31:0] o_steps
);
  logic pulse_q;
  initial
  begin
    pulse_q = 1'b0;
    o_steps = 0;
  end
  always @(posedge i_clk)
  begin
    pulse_q <= i_pulse;
    if (i_pulse && !pulse_q)
      o_steps <= o_steps + (i_reverse ? -1 : 1);
  end
endmodule

// *** dv/pulse_positioning_coordinates_bench.sv ***
// Purpose: Self-checking bench for the positioning core
// Assumes: Short control interval, 100 kpps steps
// Notes: Expected positions worked out from the move list
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module pulse_positioning_coordinates_bench;
  logic i_clk, i_rst_n, i_len_word_wr, i_move_start, i_move_abs, i_move_reverse, err;
  logic i_counter_preset_command, i_origin_found, i_out_reset, i_program_mode;
  logic [15:0] i_len_word, i_accel_rate, i_decel_rate;
  logic [31:0] i_start_freq, i_target_freq, i_preset_value, peak;
  wire o_busy, o_done, o_exec_error, o_no_origin, o_pulse, o_reverse_direction;
  wire [31:0] o_position_counter, o_freq;
  wire signed [31:0] steps;
  int miscompares, comparisons, base, k;

  ppc_positioner #(.CTRL_TICKS(200)) ppc_positioner_inst (.i_clk, .i_rst_n, .i_len_word_wr,
    .i_len_word, .i_move_start, .i_move_abs, .i_move_reverse, .i_start_freq, .i_target_freq,
    .i_accel_rate, .i_decel_rate, .i_counter_preset_command, .i_preset_value, .i_origin_found,
    .i_out_reset, .i_program_mode, .o_busy, .o_done, .o_exec_error, .o_no_origin,
    .o_position_counter, .o_freq, .o_pulse, .o_reverse_direction);
  ppc_drive_model ppc_drive_model_inst (.i_clk, .i_pulse(o_pulse),
    .i_reverse(o_reverse_direction), .o_steps(steps));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // One pulse on a command input
  task automatic strobe(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  // Length goes low word first; waits out the last step pulse
  task move(input logic ab, input logic rv, input logic [31:0] n);
    // Relative counts must stay non-negative
    `CHK(ab | ~n[31], 1'b1)
    i_len_word_wr = 1'b1;
    i_len_word = n[15:0];
    tick(1);
    i_len_word = n[31:16];
    tick(1);
    i_len_word_wr = 1'b0;
    i_move_start = 1'b1;
    i_move_abs = ab;
    i_move_reverse = rv;
    base = steps;
    tick(1);
    i_move_start = 1'b0;
    for (k = 0; k < 40000 && o_done !== 1'b1 && o_exec_error !== 1'b1; k++)
    begin
      if (o_freq > peak)
        peak = o_freq;
      tick(1);
    end
    err = o_exec_error;
    `CHK(k < 40000, 1'b1)
    tick(600);
  endtask

  task wrap_up;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #500_000;
    miscompares++;
    wrap_up;
  end

  initial
  begin
    {i_len_word_wr, i_move_start, i_move_abs, i_move_reverse} = 4'h0;
    {i_counter_preset_command, i_origin_found, i_out_reset, i_program_mode} = 4'h0;
    i_len_word = 16'h0;
    i_start_freq = 32'h0001_86a0;
    i_target_freq = 32'h0001_86a0;
    i_accel_rate = 16'h03e8;
    i_decel_rate = 16'h03e8;
    i_preset_value = 32'h0000_000a;
    peak = 32'h0;
    i_rst_n = 1'b0;
    tick(10);
    i_rst_n = 1'b1;
    tick(1);
    `CHK(o_no_origin, 1'b1)
    move(1'b1, 1'b0, 32'h5);
    `CHK(err, 1'b1)
    `CHK(steps - base, 0)
    $display("test refusal done");
    move(1'b0, 1'b0, 32'h5);
    `CHK(o_position_counter, 32'h5)
    `CHK(steps - base, 5)
    move(1'b0, 1'b1, 32'h3);
    `CHK(o_position_counter, 32'hffff_fffd)
    `CHK(steps - base, -3)
    $display("test relative done");
    strobe(i_counter_preset_command);
    `CHK(o_no_origin, 1'b0)
    `CHK(o_position_counter, 32'ha)
    move(1'b0, 1'b0, 32'h4);
    `CHK(o_position_counter, 32'he)
    move(1'b1, 1'b0, 32'hc);
    `CHK(steps - base, -2)
    `CHK(o_position_counter, 32'hc)
    move(1'b1, 1'b0, 32'hc);
    `CHK(steps - base, 0)
    move(1'b1, 1'b1, 32'hf);
    `CHK(steps - base, 3)
    $display("test absolute done");
    strobe(i_origin_found);
    `CHK(o_position_counter, 32'h0)
    strobe(i_out_reset);
    `CHK(o_no_origin, 1'b1)
    strobe(i_counter_preset_command);
    i_program_mode = 1'b1;
    tick(2);
    `CHK(o_no_origin, 1'b1)
    i_program_mode = 1'b0;
    $display("test origin done");
    i_target_freq = 32'h0002_e630;
    i_accel_rate = 16'h4e20;
    i_decel_rate = 16'h4e20;
    peak = 32'h0;
    move(1'b0, 1'b0, 32'ha);
    `CHK(o_position_counter, 32'ha)
    `CHK(peak < i_target_freq, 1'b1)
    `CHK(peak >= i_start_freq, 1'b1)
    $display("test triangle done");
    wrap_up;
  end
endmodule

// *** rtl/ppc_defs.vh ***
// Purpose: Shared constants for the pulse positioning block
// Assumes: 100 MHz system clock, one pulse output
// Notes: Included by every design file of the block
// How it works
// - Relative coordinates until origin, then absolute
// - Relative move emits exactly the requested count
// - No origin: position zeroed before relative pulses
// - Origin set: relative count added to position
// - Position is signed 32-bit, full range
// - Absolute without origin: refused, error, no pulses
// - Absolute count and direction from target difference
// - No-origin flag kept, cleared once origin defined
// - Output reset flag makes origin undefined again
// - Entering programming mode makes origin undefined
// - Unreachable speed lowers peak, triangular profile
// - Rates change frequency once per 4 ms
`ifndef PPC_DEFS_VH
`define PPC_DEFS_VH

`define PPC_CLK_NS 10
`define PPC_CLK_HZ 33'h0_05f5_e100
`define PPC_CTRL_MS 4
// Control intervals per second at 4 ms; sized so it can sit in a concatenation
`define PPC_TICKS_PER_S 32'h0000_00fa
`define PPC_PULSE_HI 10'h1f4
`define PPC_POS_ZERO 32'h0000_0000
`define PPC_POS_STEP 32'h0000_0001
`define PPC_FREQ_MIN 32'h0000_0001

`define PPC_ST_IDLE 2'h0
`define PPC_ST_CALC 2'h1
`define PPC_ST_RUN 2'h2

`endif

// *** rtl/ppc_positioner.v ***
// Purpose: Positioning core for one pulse and direction output
// Assumes: Command inputs are synchronous to i_clk
// Notes: Linear acceleration only; origin search lives elsewhere
`timescale 1ns/1ps
`include "ppc_defs.vh"

module ppc_positioner
#(
  parameter CTRL_TICKS = (`PPC_CTRL_MS * 1000000) / `PPC_CLK_NS
)
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Move length words, low word first
  input wire i_len_word_wr,
  input wire [15:0] i_len_word,
  // Move command
  input wire i_move_start,
  input wire i_move_abs,
  input wire i_move_reverse,
  input wire [31:0] i_start_freq,
  input wire [31:0] i_target_freq,
  input wire [15:0] i_accel_rate,
  input wire [15:0] i_decel_rate,
  // Origin control
  input wire i_counter_preset_command,
  input wire [31:0] i_preset_value,
  input wire i_origin_found,
  input wire i_out_reset,
  input wire i_program_mode,
  // Status
  output reg o_busy,
  output reg o_done,
  output reg o_exec_error,
  output reg o_no_origin,
  output reg [31:0] o_position_counter,
  output reg [31:0] o_freq,
  // Driver pins
  output reg o_pulse,
  output reg o_reverse_direction
);

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] len_q;
  reg word_hi_q;
  reg prog_q;
  reg [31:0] rem_q;
  reg [31:0] target_q;
  reg [31:0] freq_q;
  reg [31:0] start_q;
  reg [31:0] peak_q;
  reg [15:0] acc_rate_q;
  reg [15:0] dec_rate_q;
  reg braking_q;
  reg abs_q;
  reg [31:0] tick_q;
  wire tick = (tick_q == 32'h0);
  wire step;
  wire level;

  // Signed difference for absolute targets, one bit wider than the operands
  wire [32:0] diff = {target_q[31], target_q} - {o_position_counter[31], o_position_counter};
  wire [32:0] diff_mag = diff[32] ? (33'h0 - diff) : diff;
  wire prog_enter = i_program_mode & ~prog_q;
  wire undefine = i_out_reset | prog_enter;
  wire run_en = (state_q == `PPC_ST_RUN) && (rem_q != `PPC_POS_ZERO) && !undefine;

  // Braking distance test: rem * 2 * dec * ticks/s <= f^2 - start^2
  wire [63:0] brake_lhs = {32'h0, rem_q} * {39'h0, dec_rate_q, 9'h0} / 64'h100
                          * {32'h0, `PPC_TICKS_PER_S};
  wire [63:0] brake_rhs = {32'h0, freq_q} * {32'h0, freq_q}
                          - {32'h0, start_q} * {32'h0, start_q};
  wire must_brake = brake_lhs <= brake_rhs;

  ppc_pulse_gen u_gen
  (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(run_en),
    .i_freq(freq_q),
    .o_step(step),
    .o_level(level)
  );

  always @*
  begin
    state_d = state_q;
    case (state_q)
      `PPC_ST_IDLE:
        if (i_move_start && !undefine && !(i_move_abs && o_no_origin))
          state_d = `PPC_ST_CALC;
      `PPC_ST_CALC:
        state_d = `PPC_ST_RUN;
      `PPC_ST_RUN:
        if (undefine || rem_q == `PPC_POS_ZERO ||
            (step && rem_q == `PPC_POS_STEP))
          state_d = `PPC_ST_IDLE;
      default:
        state_d = `PPC_ST_IDLE;
    endcase
  end

  // Count length words; the pair must be complete before a start
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      len_q <= `PPC_POS_ZERO;
      word_hi_q <= 1'b0;
      prog_q <= 1'b0;
    end
    else
    begin
      prog_q <= i_program_mode;
      if (i_len_word_wr)
      begin
        word_hi_q <= ~word_hi_q;
        if (word_hi_q)
          len_q[31:16] <= i_len_word;
        else
          len_q[15:0] <= i_len_word;
      end
    end
  end

  // Origin tracking; undefine wins over a definition in the same cycle
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_no_origin <= 1'b1;
    else if (undefine)
      o_no_origin <= 1'b1;
    else if (i_counter_preset_command || i_origin_found)
      o_no_origin <= 1'b0;
  end

  // Control interval timer, restarted with every move
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_q <= `PPC_POS_ZERO;
    else if (state_q != `PPC_ST_RUN || tick)
      tick_q <= CTRL_TICKS - 1;
    else
      tick_q <= tick_q - `PPC_POS_STEP;
  end

  // Move setup, counting and frequency profile
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q <= `PPC_ST_IDLE;
      rem_q <= `PPC_POS_ZERO;
      target_q <= `PPC_POS_ZERO;
      freq_q <= `PPC_POS_ZERO;
      start_q <= `PPC_POS_ZERO;
      peak_q <= `PPC_POS_ZERO;
      acc_rate_q <= 16'h0;
      dec_rate_q <= 16'h0;
      braking_q <= 1'b0;
      abs_q <= 1'b0;
      o_position_counter <= `PPC_POS_ZERO;
      o_reverse_direction <= 1'b0;
      o_exec_error <= 1'b0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_freq <= `PPC_POS_ZERO;
      o_pulse <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      o_exec_error <= 1'b0;
      o_done <= 1'b0;
      o_busy <= (state_d != `PPC_ST_IDLE);
      o_pulse <= level;
      o_freq <= run_en ? freq_q : `PPC_POS_ZERO;
      if (i_counter_preset_command && state_q == `PPC_ST_IDLE)
        o_position_counter <= i_preset_value;
      else if (i_origin_found && state_q == `PPC_ST_IDLE)
        o_position_counter <= `PPC_POS_ZERO;
      case (state_q)
        `PPC_ST_IDLE:
          if (i_move_start)
          begin
            if (i_move_abs && o_no_origin)
              o_exec_error <= 1'b1;
            else if (!undefine)
            begin
              target_q <= len_q;
              start_q <= (i_start_freq == `PPC_POS_ZERO) ? `PPC_FREQ_MIN : i_start_freq;
              peak_q <= (i_target_freq == `PPC_POS_ZERO) ? `PPC_FREQ_MIN : i_target_freq;
              acc_rate_q <= i_accel_rate;
              dec_rate_q <= i_decel_rate;
              braking_q <= 1'b0;
              abs_q <= i_move_abs;
              if (!i_move_abs)
              begin
                // Bit 31 of a relative count is outside the allowed range
                rem_q <= {1'b0, len_q[30:0]};
                o_reverse_direction <= i_move_reverse;
                if (o_no_origin)
                  o_position_counter <= `PPC_POS_ZERO;
              end
              else
                rem_q <= `PPC_POS_ZERO;
            end
          end
        `PPC_ST_CALC:
        begin
          freq_q <= (start_q > peak_q) ? peak_q : start_q;
          // Only absolute moves take their length from the distance; a zero
          // relative count must not turn into a move back to zero
          if (abs_q && !o_no_origin)
          begin
            rem_q <= diff_mag[31:0];
            if (diff != 33'h0)
              o_reverse_direction <= diff[32];
          end
        end
        `PPC_ST_RUN:
        begin
          if (step && run_en)
          begin
            rem_q <= rem_q - `PPC_POS_STEP;
            // Wraps at the signed 32-bit limits
            if (o_reverse_direction)
              o_position_counter <= o_position_counter - `PPC_POS_STEP;
            else
              o_position_counter <= o_position_counter + `PPC_POS_STEP;
          end
          if (must_brake)
            braking_q <= 1'b1;
          if (tick)
          begin
            if (braking_q || must_brake)
              freq_q <= (freq_q > start_q + {16'h0, dec_rate_q})
                        ? freq_q - {16'h0, dec_rate_q} : start_q;
            else if (freq_q < peak_q)
              freq_q <= (peak_q - freq_q > {16'h0, acc_rate_q})
                        ? freq_q + {16'h0, acc_rate_q} : peak_q;
          end
          if (state_d == `PPC_ST_IDLE)
          begin
            o_done <= 1'b1;
            rem_q <= `PPC_POS_ZERO;
          end
        end
        default:
          rem_q <= `PPC_POS_ZERO;
      endcase
    end
  end

endmodule

// *** rtl/ppc_pulse_gen.v ***
// Purpose: Turns a frequency in pulses per second into step pulses
// Assumes: Frequency stays below the clock rate
// Notes: Phase accumulator, so the average rate is exact
`timescale 1ns/1ps
`include "ppc_defs.vh"

module ppc_pulse_gen
(
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Control
  input wire i_en,
  input wire [31:0] i_freq,
  // Outputs
  output reg o_step,
  output reg o_level
);

  reg [32:0] acc_q;
  reg [9:0] hi_cnt_q;
  wire [32:0] sum = acc_q + {1'b0, i_freq};
  wire wrap = sum >= `PPC_CLK_HZ;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      acc_q <= 33'h0;
      o_step <= 1'b0;
      o_level <= 1'b0;
      hi_cnt_q <= 10'h0;
    end
    else
    begin
      o_step <= 1'b0;
      if (!i_en)
        acc_q <= 33'h0;
      else if (wrap)
      begin
        acc_q <= sum - `PPC_CLK_HZ;
        o_step <= 1'b1;
      end
      else
        acc_q <= sum;
      // Fixed high time; shorter than one period up to 100 kpps
      if (o_step)
      begin
        o_level <= 1'b1;
        hi_cnt_q <= `PPC_PULSE_HI;
      end
      else if (hi_cnt_q != 10'h0)
        hi_cnt_q <= hi_cnt_q - 10'h1;
      else
        o_level <= 1'b0;
    end
  end

endmodule
